// File: logic/cpds_pkg.sv
// cpds_pkg: register map, field layout, timing counts and shared types
// assumes a 20 MHz pclk and a 32-bit apb slave in the charge pump block
package cpds_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_PUMP_CTRL = 8'h00;
	localparam logic [7:0] ADDR_HP_VOL    = 8'h04;
	localparam logic [7:0] ADDR_CLK_CFG   = 8'h08;
	localparam logic [7:0] ADDR_SRV_CTRL  = 8'h0c;
	localparam logic [7:0] ADDR_SRV_STAT  = 8'h10;
	localparam logic [7:0] ADDR_PUMP_STAT = 8'h14;

	// pump control fields
	localparam int BIT_PUMP_ENABLE = 0;
	localparam int BIT_PUMP_DYN    = 1;
	// hp volume fields
	localparam int POS_VOL_LEFT    = 0;
	localparam int POS_VOL_RIGHT   = 8;
	localparam int BIT_MUTE_LEFT   = 16;
	localparam int BIT_MUTE_RIGHT  = 17;
	localparam int BIT_VU_LEFT     = 24;
	localparam int BIT_VU_RIGHT    = 25;
	localparam int VOL_W           = 7;
	// clock config fields
	localparam int POS_RATE        = 0;
	localparam int POS_RATIO       = 4;
	// servo control fields
	localparam int POS_SRV_ENA     = 0;
	localparam int POS_SRV_START   = 4;
	localparam int POS_SRV_SYNC    = 8;
	localparam int POS_SYNC_STEP   = 16;
	localparam int STEP_W          = 7;

	localparam int NCH             = 4;
	localparam int NHP             = 2;

	// reset values
	localparam logic [VOL_W-1:0] VOL_RESET = 7'h39;
	localparam logic [STEP_W-1:0] STEP_RESET = 7'h08;

	// timing: start-up correction lasts 24 ms per channel
	localparam int CLK_HZ          = 20000000;
	localparam int STARTUP_MS      = 24;
	localparam int STARTUP_CYC     = CLK_HZ / 1000 * STARTUP_MS;
	// one sync servo operation, filtered against audio
	localparam int SYNC_OP_MS      = 40;
	localparam int SYNC_OP_CYC     = CLK_HZ / 1000 * SYNC_OP_MS;
	localparam int CNT_W           = 24;
	// volume code at or above which the pump needs its high rail
	localparam logic [VOL_W-1:0] HI_VOL_CODE = 7'h6b;
	// dac level at or above which dynamic mode needs the high rail
	localparam logic [15:0] HI_LVL = 16'h4000;

	typedef enum logic [1:0] {
		CPDS_IDLE  = 2'b00,
		CPDS_START = 2'b01,
		CPDS_SYNC  = 2'b10
	} cpds_srv_state_t;

	typedef struct packed {
		cpds_srv_state_t  st;
		logic [CNT_W-1:0] cnt;
		logic [STEP_W-1:0] steps;
		logic             done;
		logic             cal;
	} cpds_chan_t;

	typedef struct packed {
		logic             enable;
		logic             dyn;
		logic [VOL_W-1:0] vol_l_pend;
		logic [VOL_W-1:0] vol_r_pend;
		logic             mute_l_pend;
		logic             mute_r_pend;
		logic [VOL_W-1:0] vol_l;
		logic [VOL_W-1:0] vol_r;
		logic             mute_l;
		logic             mute_r;
		logic             hi_mode;
		logic [2:0]       rate;
		logic [3:0]       ratio;
		logic [NCH-1:0]   srv_ena;
		logic [STEP_W-1:0] sync_step;
		logic [31:0]      prdata;
	} cpds_regs_t;

endpackage : cpds_pkg

// File: logic/cpds_servo_chan.sv
// cpds_servo_chan: one dc servo channel sequencer
// assumes pump_ok qualifies every measurement; start and sync are pulses
`timescale 1ns/1ns
`default_nettype none
module cpds_servo_chan #(
	parameter bit HAS_SYNC = 1'b1
) (
	// clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// control
	input  wire logic                       enable,
	input  wire logic                       pump_ok,
	input  wire logic                       start,
	input  wire logic                       sync,
	input  wire logic [cpds_pkg::STEP_W-1:0] sync_step,
	// status
	output logic                            busy,
	output logic                            done,
	output logic                            calibrated
);
	cpds_pkg::cpds_chan_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		unique case (s_q.st)
			cpds_pkg::CPDS_IDLE: begin
				if (start && enable && pump_ok) begin
					s_d.st   = cpds_pkg::CPDS_START; // RULE_12
					s_d.cnt  = cpds_pkg::CNT_W'(cpds_pkg::STARTUP_CYC - 1);
					s_d.done = 1'b0; // RULE_24
				end else if (HAS_SYNC && sync && enable && pump_ok &&
					sync_step != '0) begin
					s_d.st    = cpds_pkg::CPDS_SYNC; // RULE_18 RULE_21
					s_d.steps = sync_step; // RULE_19
					s_d.cnt   = cpds_pkg::CNT_W'(cpds_pkg::SYNC_OP_CYC - 1);
				end
			end
			cpds_pkg::CPDS_START: begin
				// measurement only advances while the pump supply is up
				if (pump_ok && enable) begin // RULE_17
					if (s_q.cnt == '0) begin
						s_d.st   = cpds_pkg::CPDS_IDLE;
						s_d.done = 1'b1; // RULE_13
						s_d.cal  = 1'b1; // RULE_16
					end else begin
						s_d.cnt = s_q.cnt - 1'b1;
					end
				end
			end
			cpds_pkg::CPDS_SYNC: begin
				if (pump_ok && enable) begin // RULE_17
					if (s_q.cnt != '0) begin
						s_d.cnt = s_q.cnt - 1'b1; // RULE_20
					end else if (s_q.steps == 7'h01) begin
						s_d.st  = cpds_pkg::CPDS_IDLE;
						s_d.cal = 1'b1;
					end else begin
						s_d.steps = s_q.steps - 1'b1;
						s_d.cnt   = cpds_pkg::CNT_W'(cpds_pkg::SYNC_OP_CYC - 1);
					end
				end
			end
			default: s_d.st = cpds_pkg::CPDS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy       = (s_q.st != cpds_pkg::CPDS_IDLE);
	assign done       = s_q.done;
	assign calibrated = s_q.cal;

	sequence s_start_last;
		s_q.st == cpds_pkg::CPDS_START && s_q.cnt == '0 &&
		pump_ok && enable;
	endsequence

	sequence s_sync_go;
		HAS_SYNC && s_q.st == cpds_pkg::CPDS_IDLE && !start && sync &&
		enable && pump_ok && sync_step != '0;
	endsequence

	a_start_clears_done : assert property ( // RULE_24
		@(posedge pclk) disable iff (!presetn)
		(s_q.st == cpds_pkg::CPDS_IDLE && start && enable && pump_ok)
		|=> (!done && busy))
		else $error("start did not clear done");

	a_done_at_end : assert property ( // RULE_13
		@(posedge pclk) disable iff (!presetn)
		s_start_last |=> (done && calibrated && !busy))
		else $error("done not raised on completion");

	a_sync_launch : assert property ( // RULE_19
		@(posedge pclk) disable iff (!presetn)
		s_sync_go |=> (s_q.st == cpds_pkg::CPDS_SYNC &&
		s_q.steps == $past(sync_step)))
		else $error("sync run not launched with its step count");

	a_zero_step : assert property ( // RULE_19
		@(posedge pclk) disable iff (!presetn)
		(s_q.st == cpds_pkg::CPDS_IDLE && !start && sync_step == '0)
		|=> !busy)
		else $error("sync ran with zero steps");

	a_idle_no_pump : assert property ( // RULE_17
		@(posedge pclk) disable iff (!presetn)
		(s_q.st == cpds_pkg::CPDS_IDLE && !pump_ok) |=> !busy)
		else $error("servo launched without pump");

	a_stall_no_pump : assert property ( // RULE_17
		@(posedge pclk) disable iff (!presetn)
		(busy && !pump_ok) |=> $stable(s_q.cnt))
		else $error("servo advanced without pump");

	a_cal_retained : assert property ( // RULE_16
		@(posedge pclk) disable iff (!presetn)
		calibrated |=> calibrated)
		else $error("correction lost");

	a_sync_hp_only : assert property ( // RULE_21
		@(posedge pclk) disable iff (!presetn)
		!HAS_SYNC |-> s_q.st != cpds_pkg::CPDS_SYNC)
		else $error("sync on input channel");
endmodule : cpds_servo_chan
`default_nettype wire

// File: logic/cpds_top.sv
// cpds_top: charge pump control and four dc servo channels behind apb
// assumes pclk is the system clock and dac_level is on the pclk domain
//
// How it works
// (RULE_01) pump runs only while pump_enable is set.
// (RULE_02) pump_dynamic_select 0 picks register control, 1 dynamic control.
// (RULE_03) register control derives pump mode from active left/right volumes.
// (RULE_04) dynamic control also uses measured dac level in real time.
// (RULE_05) software writes volume update 1 to finish switch to register control.
// (RULE_06) selecting dynamic control changes pump mode at once.
// (RULE_07) reset leaves register control selected, dynamic bit clear.
// (RULE_08) software keeps register control when sidetone or enhancement runs.
// (RULE_09) pump logic works only while the system clock runs.
// (RULE_10) pump clock divides system clock by rate and ratio fields.
// (RULE_11) four servo channels, each with its own enable bit.
// (RULE_12) writing start trigger 1 runs offset measurement and correction.
// (RULE_13) per-channel done flag rises when start-up correction completes.
// (RULE_14) several channels may start together, about 24 ms each.
// (RULE_15) software mutes and shorts headphones before headphone start-up.
// (RULE_16) correction is retained while the path is disabled.
// (RULE_17) no correction unless pump is enabled and clock present.
// (RULE_18) sync trigger 1 corrects a headphone output while audio runs.
// (RULE_19) sync step count field sets number of operations, up to 127.
// (RULE_20) sync correction is filtered and runs far longer than start-up.
// (RULE_21) only headphone channels have sync mode.
// (RULE_22) software triggers sync after large gain steps.
// (RULE_23) either update bit moves both pending volumes and mutes into effect.
// (RULE_24) a new start trigger clears that channel's done flag.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module cpds_top (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// dac level from the playback path
	input  wire logic [15:0] dac_level,
	// pump controls
	output logic             pump_run,
	output logic             pump_clk_en,
	output logic             pump_hi_mode,
	// active headphone gains
	output logic [6:0]       hp_left_primary_volume,
	output logic [6:0]       hp_right_primary_volume,
	output logic             hp_left_mute,
	output logic             hp_right_mute,
	// servo status
	output logic [3:0]       servo_busy,
	output logic [3:0]       servo_calibrated
);
	////////////////////////////////////////////////////////////////////////
	cpds_pkg::cpds_regs_t r_q, r_d;

	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic [3:0]  start_p;
	logic [3:0]  sync_p;
	logic [3:0]  done_w;
	logic        vu_p;
	logic        pump_ok;
	logic [11:0] div_q;
	logic [11:0] div_lim;
	logic        hi_reg;
	logic        hi_dyn;
	logic        wr_pump;
	logic [11:0] gap_q;

	assign addr_ok = (paddr == cpds_pkg::ADDR_PUMP_CTRL) ||
		(paddr == cpds_pkg::ADDR_HP_VOL)   ||
		(paddr == cpds_pkg::ADDR_CLK_CFG)  ||
		(paddr == cpds_pkg::ADDR_SRV_CTRL) ||
		(paddr == cpds_pkg::ADDR_SRV_STAT) ||
		(paddr == cpds_pkg::ADDR_PUMP_STAT);
	// zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign wr_en   = psel && penable && pwrite && addr_ok;
	assign rd_en   = psel && !penable && !pwrite;

	// trigger bits are write-one pulses; they never store
	assign vu_p = wr_en && paddr == cpds_pkg::ADDR_HP_VOL && pstrb[3] &&
		(pwdata[cpds_pkg::BIT_VU_LEFT] || pwdata[cpds_pkg::BIT_VU_RIGHT]);
	assign start_p = (wr_en && paddr == cpds_pkg::ADDR_SRV_CTRL && pstrb[0]) ?
		pwdata[cpds_pkg::POS_SRV_START +: 4] : 4'h0;
	assign sync_p = (wr_en && paddr == cpds_pkg::ADDR_SRV_CTRL && pstrb[1]) ?
		{2'b00, pwdata[cpds_pkg::POS_SRV_SYNC +: 2]} : 4'h0;
	assign wr_pump = wr_en && paddr == cpds_pkg::ADDR_PUMP_CTRL &&
		pstrb[0];

	// the pump clock only exists while pclk runs, so no clock means no pump
	assign pump_ok = r_q.enable; // RULE_09 RULE_17

	////////////////////////////////////////////////////////////////////////
	// pump mode decisions
	assign hi_reg = (r_q.vol_l >= cpds_pkg::HI_VOL_CODE) ||
		(r_q.vol_r >= cpds_pkg::HI_VOL_CODE); // RULE_03
	assign hi_dyn = hi_reg || (dac_level >= cpds_pkg::HI_LVL); // RULE_04

	always_comb begin
		r_d = r_q;
		if (wr_en) begin
			unique case (paddr)
				cpds_pkg::ADDR_PUMP_CTRL: if (pstrb[0]) begin
					r_d.enable = pwdata[cpds_pkg::BIT_PUMP_ENABLE];
					r_d.dyn    = pwdata[cpds_pkg::BIT_PUMP_DYN]; // RULE_02
				end
				cpds_pkg::ADDR_HP_VOL: begin
					if (pstrb[0]) begin
						r_d.vol_l_pend = pwdata[cpds_pkg::POS_VOL_LEFT +: 7];
					end
					if (pstrb[1]) begin
						r_d.vol_r_pend = pwdata[cpds_pkg::POS_VOL_RIGHT +: 7];
					end
					if (pstrb[2]) begin
						r_d.mute_l_pend = pwdata[cpds_pkg::BIT_MUTE_LEFT];
						r_d.mute_r_pend = pwdata[cpds_pkg::BIT_MUTE_RIGHT];
					end
				end
				cpds_pkg::ADDR_CLK_CFG: if (pstrb[0]) begin
					r_d.rate  = pwdata[cpds_pkg::POS_RATE +: 3];
					r_d.ratio = pwdata[cpds_pkg::POS_RATIO +: 4];
				end
				cpds_pkg::ADDR_SRV_CTRL: begin
					if (pstrb[0]) begin
						r_d.srv_ena = pwdata[cpds_pkg::POS_SRV_ENA +: 4]; // RULE_11
					end
					if (pstrb[2]) begin
						r_d.sync_step = pwdata[cpds_pkg::POS_SYNC_STEP +: 7];
					end
				end
				default: r_d = r_d;
			endcase
		end
		// the update strobe carries the pending values of this same write
		if (vu_p) begin
			r_d.vol_l  = r_d.vol_l_pend; // RULE_23
			r_d.vol_r  = r_d.vol_r_pend;
			r_d.mute_l = r_d.mute_l_pend;
			r_d.mute_r = r_d.mute_r_pend;
		end
		if (r_q.dyn) begin
			r_d.hi_mode = hi_dyn; // RULE_04 RULE_06
		end else if (vu_p) begin
			// register mode only moves on a volume update
			r_d.hi_mode = (r_d.vol_l >= cpds_pkg::HI_VOL_CODE) ||
				(r_d.vol_r >= cpds_pkg::HI_VOL_CODE); // RULE_05 RULE_03
		end
		r_d.prdata = 32'h0;
		if (rd_en) begin
			unique case (paddr)
				cpds_pkg::ADDR_PUMP_CTRL: r_d.prdata = {30'h0, r_q.dyn, r_q.enable};
				cpds_pkg::ADDR_HP_VOL: r_d.prdata = {14'h0, r_q.mute_r_pend,
					r_q.mute_l_pend, 1'b0, r_q.vol_r_pend, 1'b0, r_q.vol_l_pend};
				cpds_pkg::ADDR_CLK_CFG: r_d.prdata = {24'h0, r_q.ratio, 1'b0,
					r_q.rate};
				cpds_pkg::ADDR_SRV_CTRL: r_d.prdata = {9'h0, r_q.sync_step,
					12'h0, r_q.srv_ena};
				cpds_pkg::ADDR_SRV_STAT: r_d.prdata = {20'h0, servo_calibrated,
					servo_busy, done_w};
				cpds_pkg::ADDR_PUMP_STAT: r_d.prdata = {16'h0, 1'b0,
					r_q.vol_r, 1'b0, r_q.vol_l} | {29'h0, r_q.mute_r,
					r_q.mute_l, r_q.hi_mode} << 16;
				default: r_d.prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q            <= '0;
			r_q.dyn        <= 1'b0; // RULE_07
			r_q.vol_l_pend <= cpds_pkg::VOL_RESET;
			r_q.vol_r_pend <= cpds_pkg::VOL_RESET;
			r_q.vol_l      <= cpds_pkg::VOL_RESET;
			r_q.vol_r      <= cpds_pkg::VOL_RESET;
			r_q.sync_step  <= cpds_pkg::STEP_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	assign prdata = r_q.prdata;

	////////////////////////////////////////////////////////////////////////
	// pump switching clock enable: divide by (ratio+1)*(rate+1)*16
	assign div_lim = 12'({r_q.ratio, 4'h0} * {1'b0, r_q.rate} +
		{r_q.ratio, 4'h0} + {5'h0, r_q.rate, 4'h0} + 12'h00f); // RULE_10

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 12'h000;
		end else if (!r_q.enable || div_q >= div_lim) begin
			div_q <= 12'h000;
		end else begin
			div_q <= div_q + 12'h001;
		end
	end

	// cycles since the last switching enable; a check aid only, it
	// saturates so that a run of config writes cannot wrap it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= 12'h000;
		end else if (pump_clk_en || !r_q.enable) begin
			gap_q <= 12'h000;
		end else if (gap_q != 12'hfff) begin
			gap_q <= gap_q + 12'h001;
		end
	end

	assign pump_run    = r_q.enable; // RULE_01
	assign pump_clk_en = r_q.enable && (div_q == div_lim); // RULE_01 RULE_10
	assign pump_hi_mode = r_q.hi_mode;
	assign hp_left_primary_volume  = r_q.vol_l;
	assign hp_right_primary_volume = r_q.vol_r;
	assign hp_left_mute  = r_q.mute_l;
	assign hp_right_mute = r_q.mute_r;

	////////////////////////////////////////////////////////////////////////
	// channels 0,1 headphone left/right; 2,3 input left/right
	genvar g;
	generate
		for (g = 0; g < cpds_pkg::NCH; g++) begin : g_chan
			cpds_servo_chan #(
				.HAS_SYNC (g < cpds_pkg::NHP) // RULE_21
			) u_chan (
				.pclk       (pclk),
				.presetn    (presetn),
				.enable     (r_q.srv_ena[g]),
				.pump_ok    (pump_ok),
				.start      (start_p[g]), // RULE_14
				.sync       (sync_p[g]),
				.sync_step  (r_q.sync_step),
				.busy       (servo_busy[g]),
				.done       (done_w[g]),
				.calibrated (servo_calibrated[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	sequence s_vu_write;
		vu_p && !r_q.dyn;
	endsequence

	sequence s_dyn_select;
		wr_pump && pwdata[cpds_pkg::BIT_PUMP_DYN] && !r_q.dyn;
	endsequence

	a_pump_gated : assert property ( // RULE_01
		@(posedge pclk) disable iff (!presetn)
		pump_clk_en |-> pump_run)
		else $error("pump clock while off");

	a_pump_write : assert property ( // RULE_01
		@(posedge pclk) disable iff (!presetn)
		wr_pump |=>
		(pump_run == $past(pwdata[cpds_pkg::BIT_PUMP_ENABLE])))
		else $error("pump enable not taken");

	a_dyn_write : assert property ( // RULE_02
		@(posedge pclk) disable iff (!presetn)
		wr_pump |=> (r_q.dyn == $past(pwdata[cpds_pkg::BIT_PUMP_DYN])))
		else $error("control method not taken");

	a_reset_reg_ctl : assert property ( // RULE_07
		@(posedge pclk)
		!presetn |-> (!r_q.dyn && !pump_run))
		else $error("reset left dynamic control on");

	a_reg_mode_hold : assert property ( // RULE_05
		@(posedge pclk) disable iff (!presetn)
		(!r_q.dyn && !vu_p) |=> $stable(pump_hi_mode))
		else $error("register mode changed without update");

	a_reg_mode_vu : assert property ( // RULE_03
		@(posedge pclk) disable iff (!presetn)
		s_vu_write |=> (pump_hi_mode == hi_reg))
		else $error("update did not set pump mode");

	a_dyn_immediate : assert property ( // RULE_06
		@(posedge pclk) disable iff (!presetn)
		(r_q.dyn && !vu_p && $stable(dac_level)) |=>
		(pump_hi_mode == $past(hi_dyn)))
		else $error("dynamic mode not applied");

	a_dyn_select : assert property ( // RULE_06
		@(posedge pclk) disable iff (!presetn)
		s_dyn_select |-> ##2 (pump_hi_mode == $past(hi_dyn)))
		else $error("dynamic selection not applied at once");

	a_dac_level_hi : assert property ( // RULE_04
		@(posedge pclk) disable iff (!presetn)
		(r_q.dyn && dac_level >= cpds_pkg::HI_LVL) |=> pump_hi_mode)
		else $error("dac level ignored in dynamic mode");

	a_vu_both : assert property ( // RULE_23
		@(posedge pclk) disable iff (!presetn)
		vu_p |=> (hp_left_primary_volume == r_q.vol_l_pend &&
		hp_right_primary_volume == r_q.vol_r_pend))
		else $error("volumes not moved together");

	a_vu_mutes : assert property ( // RULE_23
		@(posedge pclk) disable iff (!presetn)
		vu_p |=> (hp_left_mute == r_q.mute_l_pend &&
		hp_right_mute == r_q.mute_r_pend))
		else $error("mutes not moved together");

	a_vol_hold : assert property ( // RULE_23
		@(posedge pclk) disable iff (!presetn)
		!vu_p |=> $stable(hp_left_primary_volume))
		else $error("volume changed without update");

	a_div_period : assert property ( // RULE_10
		@(posedge pclk) disable iff (!presetn)
		(pump_clk_en && div_lim == 12'h00f && $stable(r_q)) |=>
		!pump_clk_en [*8])
		else $error("pump divider too fast");

	a_div_not_early : assert property ( // RULE_10
		@(posedge pclk) disable iff (!presetn)
		pump_clk_en |-> (gap_q >= div_lim))
		else $error("pump enable came early");

	a_srv_ena_write : assert property ( // RULE_11
		@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == cpds_pkg::ADDR_SRV_CTRL && pstrb[0]) |=>
		(r_q.srv_ena == $past(pwdata[cpds_pkg::POS_SRV_ENA +: 4])))
		else $error("servo enables not taken");

	a_no_pump_idle : assert property ( // RULE_17
		@(posedge pclk) disable iff (!presetn)
		(!pump_ok && servo_busy == 4'h0) |=> $stable(servo_calibrated))
		else $error("correction without pump");

	a_unmapped_read : assert property (
		@(posedge pclk) disable iff (!presetn)
		(rd_en && !addr_ok) |=> (prdata == 32'h0))
		else $error("unmapped read returned data");
endmodule : cpds_top
`default_nettype wire

// File: tb/cpds_top_tb.sv
// cpds_top_tb: register-level bench for the pump and servo control block
// assumes an apb slave that may wait; servo runs last far too long to finish,
// so only their launch and refusal are observed
`timescale 1ns/1ns
`default_nettype none
module cpds_top_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] dac_level;
	logic        pump_run;
	logic        pump_clk_en;
	logic        pump_hi_mode;
	logic [6:0]  vol_l;
	logic [6:0]  vol_r;
	logic        mute_l;
	logic        mute_r;
	logic [3:0]  servo_busy;
	logic [3:0]  servo_calibrated;
	logic [31:0] r;
	logic        err_seen;
	int          errors;
	int          n_compared;
	int          cycles;

	cpds_top i_cpds_top (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.psel                    (psel),
		.penable                 (penable),
		.pwrite                  (pwrite),
		.paddr                   (paddr),
		.pwdata                  (pwdata),
		.pstrb                   (pstrb),
		.prdata                  (prdata),
		.pready                  (pready),
		.pslverr                 (pslverr),
		.dac_level               (dac_level),
		.pump_run                (pump_run),
		.pump_clk_en             (pump_clk_en),
		.pump_hi_mode            (pump_hi_mode),
		.hp_left_primary_volume  (vol_l),
		.hp_right_primary_volume (vol_r),
		.hp_left_mute            (mute_l),
		.hp_right_mute           (mute_r),
		.servo_busy              (servo_busy),
		.servo_calibrated        (servo_calibrated)
	);

	////////////////////////////////////////////////////////////////////////
	always #25 pclk = ~pclk;

	// ceiling far above the few hundred cycles the sequence needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end

	task automatic results();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one apb transfer; the answer is taken at the edge that samples pready
	task automatic xfer(logic w, logic [7:0] a, logic [31:0] d,
		output logic [31:0] q, output logic se);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q       = prdata;
		se      = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x, err_seen);
	endtask : wr

	task automatic rd(logic [7:0] a);
		xfer(1'b0, a, 32'h0, r, err_seen);
	endtask : rd

	task automatic settle();
		repeat (2) @(posedge pclk);
		@(negedge pclk);
	endtask : settle

	// cycles between two switching enables of the pump
	task automatic period(int exp);
		int n;
		n = 0;
		while (pump_clk_en !== 1'b1 && n < 2000) begin
			@(negedge pclk);
			n++;
		end
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (pump_clk_en !== 1'b1 && n < 2000);
		check("pump_clk_period", n, exp);
	endtask : period

	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk      = 1'b0;
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		pstrb     = 4'hf;
		dac_level = 16'h0000;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(cpds_pkg::ADDR_PUMP_CTRL);
		check("pump_ctrl", r, 32'h0);
		check("pready", pready, 32'h1);
		rd(cpds_pkg::ADDR_PUMP_STAT);
		check("pump_stat", r, 32'h0000_3939);
		check("pump_run", pump_run, 32'h0);
		rd(cpds_pkg::ADDR_SRV_CTRL);
		check("step_reset", r & 32'h007f_0000, 32'h0008_0000);
		wr(cpds_pkg::ADDR_PUMP_CTRL, 32'h1);
		settle();
		check("pump_run", pump_run, 32'h1);
		// two divider settings: (ratio+1)*(rate+1)*16
		wr(cpds_pkg::ADDR_CLK_CFG, 32'h01);
		period(32);
		wr(cpds_pkg::ADDR_CLK_CFG, 32'h20);
		period(48);
		// pending volumes stay pending until an update bit
		wr(cpds_pkg::ADDR_HP_VOL, 32'h0003_6b10);
		rd(cpds_pkg::ADDR_PUMP_STAT);
		check("pump_stat", r, 32'h0000_3939);
		wr(cpds_pkg::ADDR_HP_VOL, 32'h0203_6b10);
		settle();
		check("vol_l", vol_l, 32'h10);
		check("mute_l", mute_l, 32'h1);
		check("vol_r", vol_r, 32'h6b);
		check("mute_r", mute_r, 32'h1);
		rd(cpds_pkg::ADDR_PUMP_STAT);
		check("pump_stat", r, 32'h0007_6b10);
		wr(cpds_pkg::ADDR_HP_VOL, 32'h0100_2010);
		rd(cpds_pkg::ADDR_PUMP_STAT);
		check("pump_stat", r, 32'h0000_2010);
		// dynamic control follows the dac level without any update
		dac_level <= 16'h4000;
		wr(cpds_pkg::ADDR_PUMP_CTRL, 32'h3);
		settle();
		check("hi_mode", pump_hi_mode, 32'h1);
		dac_level <= 16'h3fff;
		settle();
		check("hi_mode", pump_hi_mode, 32'h0);
		dac_level <= 16'h4000;
		settle();
		check("hi_mode", pump_hi_mode, 32'h1);
		// back to register control, completed by an update write
		wr(cpds_pkg::ADDR_PUMP_CTRL, 32'h1);
		settle();
		check("hi_mode", pump_hi_mode, 32'h1);
		wr(cpds_pkg::ADDR_HP_VOL, 32'h0100_2010);
		settle();
		check("hi_mode", pump_hi_mode, 32'h0);
		// servo start refused while the pump is off
		wr(cpds_pkg::ADDR_PUMP_CTRL, 32'h0);
		wr(cpds_pkg::ADDR_SRV_CTRL, 32'h0008_0005);
		wr(cpds_pkg::ADDR_SRV_CTRL, 32'h0008_0015);
		settle();
		check("servo_busy", servo_busy, 32'h0);
		// start ch0 and ch2 together; ch1 disabled so its start is ignored
		wr(cpds_pkg::ADDR_HP_VOL, 32'h0103_2010);
		wr(cpds_pkg::ADDR_PUMP_CTRL, 32'h1);
		wr(cpds_pkg::ADDR_SRV_CTRL, 32'h0008_007d);
		settle();
		check("servo_busy", servo_busy, 32'h5);
		rd(cpds_pkg::ADDR_SRV_STAT);
		check("srv_stat", r, 32'h0000_0050);
		check("calibrated", servo_calibrated, 32'h0);
		// sync with a zero step count does nothing, a nonzero one runs
		wr(cpds_pkg::ADDR_SRV_CTRL, 32'h0000_000f);
		wr(cpds_pkg::ADDR_SRV_CTRL, 32'h0000_020f);
		settle();
		check("servo_busy", servo_busy, 32'h5);
		wr(cpds_pkg::ADDR_HP_VOL, 32'h0100_4010);
		wr(cpds_pkg::ADDR_SRV_CTRL, 32'h0003_000f);
		wr(cpds_pkg::ADDR_SRV_CTRL, 32'h0003_020f);
		settle();
		check("servo_busy", servo_busy, 32'h7);
		check("vol_r", vol_r, 32'h40);
		// unmapped offsets answer with an error and read zero
		rd(8'h18);
		check("rd_unmapped", r, 32'h0);
		check("rd_slverr", err_seen, 32'h1);
		wr(8'h1c, 32'hffff_ffff);
		check("wr_slverr", err_seen, 32'h1);
		results();
	end
endmodule : cpds_top_tb
`default_nettype wire
